// file: logic/imat_pkg.sv
// Package for the multi-address I2C target match block.
// Assumes a single system clock and a synchronous active-high reset.
`default_nettype none
package imat_pkg;
    // Address geometry
    localparam int IMAT_ADDR_W = 10;
    localparam int IMAT_HI_W = 2;
    localparam int IMAT_LO_W = 8;
    localparam int IMAT_NUM_ADDR = 4;
    // First-byte prefix in bits 7:3
    localparam logic [4:0] IMAT_PREFIX = 5'h1E;
    // Byte assembly
    localparam logic [3:0] IMAT_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] IMAT_BIT_CNT_RST = 4'h0;
    // Controller states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR1 = 6'h02,
        ST_ACK1 = 6'h04,
        ST_ADDR2 = 6'h08,
        ST_ACK2 = 6'h10,
        ST_DATA = 6'h20
    } imat_state_type;
endpackage
`default_nettype wire

// file: logic/imat_bus_cond.sv
// Start, stop and rising-clock detection on sampled I2C lines.
// Assumes sclIn and sdaIn are already synchronous to mclk.
`default_nettype none
module imat_bus_cond
    import imat_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Bus lines
    input wire logic sclIn,
    input wire logic sdaIn,
    // Detected conditions
    output logic startSeen,
    output logic stopSeen,
    output logic sclRise,
    output logic sclFall
);
    logic sclPrev_q, sclPrev_d;
    logic sdaPrev_q, sdaPrev_d;

    // Previous line levels
    always_comb begin
        sclPrev_d = sclIn;
        sdaPrev_d = sdaIn;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclPrev_d;
            sdaPrev_q <= sdaPrev_d;
        end
    end

    // Conditions from edges
    assign startSeen = sclIn && sclPrev_q && sdaPrev_q && !sdaIn;
    assign stopSeen = sclIn && sclPrev_q && !sdaPrev_q && sdaIn;
    assign sclRise = sclIn && !sclPrev_q;
    assign sclFall = !sclIn && sclPrev_q;
endmodule
`default_nettype wire

// file: logic/imat_target_match.sv
// Address recognition for an I2C target with up to four 10-bit own addresses.
// Assumes synchronous SCL/SDA samples; SDA is open drain, driven low only.
//
// Overview of operation
// - Up to four 10-bit own addresses, each an independent target identity.
// - First byte is prefix 11110, two high address bits, then direction bit.
// - Second byte carries the low eight address bits.
// - Ack first byte when high bits equal those of any active own address (enabled, and slot 0 unless multiEn).
// - Ack second byte only when all ten bits equal one own address.
// - Never ack high bits of one address joined with low bits of another.
// - Enter data state only after a full match; never take foreign data.
`default_nettype none
module imat_target_match
    import imat_pkg::*;
#(
    parameter int NUM_ADDR = IMAT_NUM_ADDR
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Configuration
    input wire logic multiEn,
    input wire logic [NUM_ADDR-1:0] addrEn,
    input wire logic [NUM_ADDR*IMAT_ADDR_W-1:0] ownAddr,
    // I2C pins
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // Match results
    output logic addrMatched,
    output logic [NUM_ADDR-1:0] matchIdx,
    output logic readDir,
    output logic [7:0] rxData,
    output logic rxValid
);
    imat_state_type state_q, state_d;
    logic [3:0] bitCnt_q, bitCnt_d;
    logic [7:0] shift_q, shift_d;
    logic [NUM_ADDR-1:0] hiHit_q, hiHit_d;
    logic [NUM_ADDR-1:0] match_q, match_d;
    logic rw_q, rw_d;
    logic [IMAT_HI_W-1:0] addrHi_q, addrHi_d;
    logic ackDrive_q, ackDrive_d;
    logic [7:0] rxData_q, rxData_d;
    logic rxValid_q, rxValid_d;
    logic startSeen, stopSeen, sclRise, sclFall;
    logic [7:0] byteNow;
    logic [NUM_ADDR-1:0] hiNow, fullNow;
    logic [NUM_ADDR-1:0] refNow, refHeld;
    logic [IMAT_ADDR_W-1:0] ownSel;

    imat_bus_cond u_cond (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .startSeen(startSeen),
        .stopSeen(stopSeen),
        .sclRise(sclRise),
        .sclFall(sclFall)
    );

    // Own address slice
    function automatic logic [IMAT_ADDR_W-1:0] ownOf(input int i,
            input logic [NUM_ADDR*IMAT_ADDR_W-1:0] all);
        ownOf = all[i*IMAT_ADDR_W +: IMAT_ADDR_W];
    endfunction

    // Slot active: enabled, and slot 0 or multi-target mode on
    function automatic logic idActive(input int i, input logic [NUM_ADDR-1:0] en,
            input logic multi);
        idActive = en[i] && (i == 0 || multi);
    endfunction

    // Byte as it completes on this rising edge
    assign byteNow = {shift_q[6:0], sdaIn};

    // Per-address compare; full match is per address, never mixed
    always_comb begin
        hiNow = '0;
        fullNow = '0;
        refNow = '0;
        refHeld = '0;
        ownSel = '0;
        for (int i = 0; i < NUM_ADDR; i++) begin
            ownSel = ownOf(i, ownAddr);
            hiNow[i] = idActive(i, addrEn, multiEn)
                && byteNow[7:3] == IMAT_PREFIX
                && byteNow[2:1] == ownSel[IMAT_ADDR_W-1 -: IMAT_HI_W];
            fullNow[i] = hiHit_q[i]
                && byteNow == ownSel[IMAT_LO_W-1:0];
            // Check reference: all ten bits against one single address
            refNow[i] = idActive(i, addrEn, multiEn) && ownSel == {addrHi_q, byteNow};
            refHeld[i] = idActive(i, addrEn, multiEn) && ownSel == {addrHi_q, shift_q};
        end
    end

    // Next-state logic
    always_comb begin
        state_d = state_q;
        bitCnt_d = bitCnt_q;
        shift_d = shift_q;
        hiHit_d = hiHit_q;
        match_d = match_q;
        rw_d = rw_q;
        addrHi_d = addrHi_q;
        ackDrive_d = ackDrive_q;
        rxData_d = rxData_q;
        rxValid_d = 1'b0;
        if (startSeen) begin
            state_d = ST_ADDR1;
            bitCnt_d = IMAT_BIT_CNT_RST;
            hiHit_d = '0;
            match_d = '0;
            ackDrive_d = 1'b0;
        end else if (stopSeen) begin
            state_d = ST_IDLE;
            match_d = '0;
            ackDrive_d = 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    ackDrive_d = 1'b0;
                end
                ST_ADDR1, ST_ADDR2, ST_DATA: begin
                    if (sclRise) begin
                        shift_d = byteNow;
                        bitCnt_d = bitCnt_q + 4'h1;
                        if (bitCnt_q == IMAT_BITS_PER_BYTE - 4'h1) begin
                            bitCnt_d = IMAT_BIT_CNT_RST;
                            if (state_q == ST_ADDR1) begin
                                hiHit_d = hiNow;
                                rw_d = byteNow[0];
                                addrHi_d = byteNow[2:1];
                                state_d = (|hiNow) ? ST_ACK1 : ST_IDLE;
                            end else if (state_q == ST_ADDR2) begin
                                match_d = fullNow;
                                state_d = (|fullNow) ? ST_ACK2 : ST_IDLE;
                            end else begin
                                rxData_d = byteNow;
                                rxValid_d = 1'b1;
                                state_d = ST_ACK2;
                            end
                        end
                    end
                end
                ST_ACK1, ST_ACK2: begin
                    // Drive ack from the falling edge after bit 8 to the next fall
                    if (sclFall) begin
                        if (!ackDrive_q) begin
                            ackDrive_d = 1'b1;
                        end else begin
                            ackDrive_d = 1'b0;
                            state_d = (state_q == ST_ACK1) ? ST_ADDR2 : ST_DATA;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    ackDrive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            bitCnt_q <= IMAT_BIT_CNT_RST;
            shift_q <= 8'h00;
            hiHit_q <= '0;
            match_q <= '0;
            rw_q <= 1'b0;
            addrHi_q <= '0;
            ackDrive_q <= 1'b0;
            rxData_q <= 8'h00;
            rxValid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            bitCnt_q <= bitCnt_d;
            shift_q <= shift_d;
            hiHit_q <= hiHit_d;
            match_q <= match_d;
            rw_q <= rw_d;
            addrHi_q <= addrHi_d;
            ackDrive_q <= ackDrive_d;
            rxData_q <= rxData_d;
            rxValid_q <= rxValid_d;
        end
    end

    // Open-drain pin and result outputs
    assign sdaOut = 1'b0;
    assign sdaOe = ackDrive_q;
    assign addrMatched = |match_q;
    assign matchIdx = match_q;
    assign readDir = rw_q;
    assign rxData = rxData_q;
    assign rxValid = rxValid_q;

    // Checks
    a_data_needs_match: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_DATA) |-> $onehot0(match_q) && (|match_q))
        else $error("data state without full address match");
    a_rx_only_matched: assert property (@(posedge mclk) disable iff (sys_rst)
        rxValid_q |-> (|match_q))
        else $error("byte captured without match");
    a_ack2_full_match: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_ADDR2 && state_d == ST_ACK2 && !startSeen && !stopSeen)
            |-> (|refNow))
        else $error("second ack without full match");
    a_no_mixed_ack: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_ACK2 && $past(state_q) == ST_ADDR2)
            |-> (match_q & ~refHeld) == '0)
        else $error("mixed address acknowledged");
    a_ack1_prefix: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_ADDR1 && sclRise && bitCnt_q == 4'h7 && !startSeen && !stopSeen
            && byteNow[7:3] != IMAT_PREFIX) |=> state_q == ST_IDLE)
        else $error("first byte without prefix accepted");
    a_idle_released: assert property (@(posedge mclk) disable iff (sys_rst)
        (state_q == ST_IDLE) |=> !sdaOe)
        else $error("SDA driven while idle");
    a_multi_off: assert property (@(posedge mclk) disable iff (sys_rst)
        !multiEn |-> match_q[NUM_ADDR-1:1] == '0)
        else $error("secondary address matched with multi mode off");
    a_ack_one_bit: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(sdaOe) |-> (state_q == ST_ACK1 || state_q == ST_ACK2))
        else $error("ack outside ack slot");
    c_full_match: cover property (@(posedge mclk) state_q == ST_ACK2 && !rxValid_q);
    c_rx_byte: cover property (@(posedge mclk) rxValid_q);
    c_first_nack: cover property (@(posedge mclk)
        state_q == ST_ADDR1 ##1 state_q == ST_IDLE);
    c_second_nack: cover property (@(posedge mclk)
        state_q == ST_ADDR2 ##1 state_q == ST_IDLE);
endmodule
`default_nettype wire

// file: tb/imat_i2c_ctrl.sv
// Behavioural I2C bus controller issuing 10-bit addressed transfers.
// Assumes the bench resolves the open-drain SDA line with a pull-up.
`default_nettype none
module imat_i2c_ctrl (
    // Clock and bus level
    input wire logic mclk,
    input wire logic sdaLine,
    // Driven lines
    output logic sclOut,
    output logic sdaLow
);
    timeunit 1ns;
    timeprecision 1ps;
    // Bus idles released
    initial begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    // Half an SCL period
    task automatic half();
        repeat (4) @(negedge mclk);
    endtask
    // Start or repeated start
    task automatic start();
        half();
        sdaLow = 1'b0;
        half();
        sclOut = 1'b1;
        half();
        sdaLow = 1'b1;
        half();
        sclOut = 1'b0;
    endtask
    // Stop condition
    task automatic stop();
        sdaLow = 1'b1;
        half();
        sclOut = 1'b1;
        half();
        sdaLow = 1'b0;
        half();
    endtask
    // One byte MSB first, then the ninth clock for the acknowledge
    task automatic sendByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sdaLow = ~b[i];
            half();
            sclOut = 1'b1;
            half();
            sclOut = 1'b0;
        end
        sdaLow = 1'b0;
        half();
        sclOut = 1'b1;
        half();
        ack = ~sdaLine;
        sclOut = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_imat_target_match.sv
// Self-checking bench for the multi-address target match block.
// Assumes the controller model in imat_i2c_ctrl and a pulled-up SDA.
`default_nettype none
module tb_imat_target_match
    import imat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic multiEn = 1'b1;
    logic [3:0] addrEn = 4'hF;
    // Own addresses with differing high bits
    logic [39:0] ownAddr = {10'h35A, 10'h2F0, 10'h13C, 10'h0A5};
    logic sclLine, sdaLow, sdaOut, sdaOe, addrMatched, readDir, rxValid, a1, a2, ak;
    logic [3:0] matchIdx;
    logic [7:0] rxData, rxLast;
    int n_mismatch = 0;
    int cmp_count = 0;
    int rxCnt = 0;
    wire logic sdaLine = !(sdaLow || (sdaOe && !sdaOut));
    always #2.5 mclk = ~mclk;
    // Count received data bytes
    always @(negedge mclk) begin
        if (rxValid === 1'b1) begin
            rxCnt++;
            rxLast = rxData;
        end
    end
    imat_i2c_ctrl ctrl (.mclk(mclk), .sdaLine(sdaLine), .sclOut(sclLine), .sdaLow(sdaLow));
    imat_target_match #(.NUM_ADDR(4)) uut (.mclk(mclk), .sys_rst(sysRst),
        .multiEn(multiEn), .addrEn(addrEn), .ownAddr(ownAddr), .sclIn(sclLine),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrMatched(addrMatched),
        .matchIdx(matchIdx), .readDir(readDir), .rxData(rxData), .rxValid(rxValid));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Start plus first address byte, then the second only if the first is acked
    task automatic xfer(input logic [9:0] a, input logic rw);
        ctrl.start();
        ctrl.sendByte({IMAT_PREFIX, a[9:8], rw}, a1);
        a2 = 1'b0;
        if (a1) ctrl.sendByte(a[7:0], a2);
    endtask
    // Every own address matched, then one data byte taken
    task automatic matchAll();
        int base;
        for (int i = 0; i < 4; i++) begin
            xfer(ownAddr[10*i+:10], 1'b0);
            chk("ack1", 8'h01, {7'h00, a1});
            chk("ack2", 8'h01, {7'h00, a2});
            chk("matchIdx", 8'h01 << i, {4'h0, matchIdx});
            chk("readDir", 8'h00, {7'h00, readDir});
            base = rxCnt;
            ctrl.sendByte(8'hC3 ^ 8'(i), ak);
            chk("dataAck", 8'h01, {7'h00, ak});
            chk("rxCnt", 8'h01, 8'(rxCnt - base));
            chk("rxData", 8'hC3 ^ 8'(i), rxLast);
            ctrl.stop();
            chk("matched", 8'h00, {7'h00, addrMatched});
        end
    endtask
    // High bits of one address joined with low bits of another
    task automatic mixed();
        int base;
        xfer(10'h03C, 1'b0);
        chk("ack1", 8'h01, {7'h00, a1});
        chk("ack2", 8'h00, {7'h00, a2});
        base = rxCnt;
        ctrl.sendByte(8'h55, ak);
        chk("dataAck", 8'h00, {7'h00, ak});
        chk("rxCnt", 8'h00, 8'(rxCnt - base));
        ctrl.stop();
    endtask
    // Read direction, bad prefix, disabled and single-address modes
    task automatic misc();
        xfer(ownAddr[29:20], 1'b1);
        chk("readDir", 8'h01, {7'h00, readDir});
        ctrl.stop();
        ctrl.start();
        ctrl.sendByte(8'hE8, ak);
        chk("prefixAck", 8'h00, {7'h00, ak});
        ctrl.stop();
        addrEn = 4'hD;
        xfer(ownAddr[19:10], 1'b0);
        chk("offAck", 8'h00, {7'h00, a1});
        ctrl.stop();
        addrEn = 4'hF;
        multiEn = 1'b0;
        xfer(ownAddr[19:10], 1'b0);
        chk("singleAck", 8'h00, {7'h00, a1});
        xfer(ownAddr[9:0], 1'b0);
        chk("singleAck0", 8'h01, {7'h00, a2});
        ctrl.stop();
    endtask
    // Shared high bits as software should set them, then a reset mid transfer
    task automatic sameHigh();
        multiEn = 1'b1;
        ownAddr = {10'h1F0, 10'h15A, 10'h13C, 10'h1A5};
        for (int i = 0; i < 4; i++) begin
            xfer(ownAddr[10*i+:10], 1'b0);
            chk("sharedAck", 8'h01, {7'h00, a2});
            chk("sharedIdx", 8'h01 << i, {4'h0, matchIdx});
            ctrl.stop();
        end
        xfer(ownAddr[9:0], 1'b0);
        sysRst = 1'b1;
        repeat (2) @(negedge mclk);
        sysRst = 1'b0;
        chk("rstIdx", 8'h00, {4'h0, matchIdx});
        chk("rstOe2", 8'h00, {7'h00, sdaOe});
        ctrl.stop();
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        sysRst = 1'b0;
        chk("rstOe", 8'h00, {7'h00, sdaOe});
        matchAll();
        mixed();
        misc();
        sameHigh();
        give_verdict();
    end
    // Hang guard
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
